/* File: ees_pkg_mem.sv */
// Shared constants and the byte array of the serial EEPROM target
`timescale 1ns/1ps

package ees_pkg;
  localparam int MEM_BYTES = 8192;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_COUNT = 256;
  localparam int ADDR_W = 13;
  localparam int PAGE_W = 5;
  localparam int HI_ADDR_W = 5;
  localparam int BYTE_W = 8;
  // Arbitrary value for the device type code
  localparam logic [3:0] TYPE_CODE_DEF = 4'h5;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [3:0] CNT_FIRST = 4'h1;
  localparam logic [3:0] CNT_LAST_DATA = 4'h7;
  localparam logic [3:0] CNT_BYTE = 4'h8;
  localparam logic [3:0] CNT_ACK = 4'h9;
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real PROG_TYP_MS = 1.9;
  localparam real PROG_MAX_MS = 3.0;
  localparam int PROG_CYC = int'(PROG_TYP_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int PROG_MAX_CYC = int'($floor(PROG_MAX_MS * 1.0e6 /
    CLK_PERIOD_NS));
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV = 3'h1,
    ST_WAH = 3'h3,
    ST_WAL = 3'h2,
    ST_WR = 3'h6,
    ST_PROG = 3'h7,
    ST_RD = 3'h5
  } ees_state_t;
endpackage

module ees_mem #(
  parameter int DEPTH = ees_pkg::MEM_BYTES,
  parameter int AW = ees_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [ees_pkg::BYTE_W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [ees_pkg::BYTE_W-1:0] rdata_q
);
  import ees_pkg::*;

  logic [BYTE_W-1:0] mem [DEPTH];

  // Write port and registered read port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule

/* File: ees_target.sv */
// Two-wire target engine of the serial EEPROM
`timescale 1ns/1ps

module ees_target #(
  parameter logic [3:0] TYPE_CODE = ees_pkg::TYPE_CODE_DEF,
  parameter int PROG_CYCLES = ees_pkg::PROG_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic target_select_bit_hi,
  input wire logic target_select_bit_mid,
  input wire logic target_select_bit_lo,
  output logic standby,
  output logic prog_busy
);
  import ees_pkg::*;

  localparam int PW = $clog2(PROG_CYCLES + 1);
  localparam logic [PW-1:0] PROG_END = PW'(PROG_CYCLES - 1);

  ees_state_t state_q;
  logic [BYTE_W-1:0] link_sh_q;
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [2:0] sel_sync_q;
  logic [2:0] sel_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_s;
  logic sda_s;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic byte_done;
  logic match;
  logic rd_load;
  logic [BYTE_W-1:0] rx_byte;
  logic [BYTE_W-1:0] rdata;
  logic [3:0] bit_cnt_q;
  logic ack_pend_q;
  logic cont_q;
  logic wrote_q;
  logic [HI_ADDR_W-1:0] hi_q;
  logic [ADDR_W-1:0] addr_q;
  logic [BYTE_W-1:0] tx_q;
  logic sda_oe_q;
  logic sda_o_q;
  logic [PW-1:0] prog_cnt_q;
  logic standby_q;
  logic busy_q;
  logic mem_we;

  // Link clock samples data on rising edges
  always_ff @(posedge scl_i) begin
    link_sh_q <= {link_sh_q[BYTE_W-2:0], sda_i};
  end

  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sel_sync_q <= SEL_RESET;
      sel_q <= SEL_RESET;
    end else begin
      sel_sync_q <= {target_select_bit_hi, target_select_bit_mid,
                     target_select_bit_lo};
      sel_q <= sel_sync_q;
    end
  end

  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];
  // Data edges with clock high are conditions, not data
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  // Eighth rising edge closes a byte
  assign byte_done = scl_rise && (bit_cnt_q == CNT_LAST_DATA) &&
                     (state_q != ST_PROG);
  assign rx_byte = link_sh_q;
  assign match = (rx_byte[7:4] == TYPE_CODE) && (rx_byte[3:1] == sel_q);
  assign rd_load = scl_fall && (bit_cnt_q == CNT_ACK) &&
                   (state_q == ST_RD) && cont_q;
  assign mem_we = byte_done && (state_q == ST_WR);

  // Bit position within the nine-pulse frame
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bit_cnt_q <= CNT_RESET;
    end else if (state_q == ST_PROG || start_det || stop_det) begin
      bit_cnt_q <= CNT_RESET;
    end else if (scl_rise) begin
      bit_cnt_q <= (bit_cnt_q == CNT_ACK) ? CNT_FIRST : bit_cnt_q + 4'h1;
    end
  end

  // Transaction sequencer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        // Programming ignores the bus until the timer ends
        ST_PROG: begin
          if (prog_cnt_q == PROG_END) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          if (start_det) begin
            state_q <= ST_DEV;
          end else if (stop_det) begin
            // Stop after written data starts programming
            state_q <= (state_q == ST_WR && wrote_q) ? ST_PROG : ST_IDLE;
          end else if (byte_done) begin
            case (state_q)
              ST_DEV: begin
                if (!match) begin
                  state_q <= ST_IDLE;
                // Direction bit picks read or write
                end else if (rx_byte[0]) begin
                  state_q <= ST_RD;
                end else begin
                  state_q <= ST_WAH;
                end
              end
              ST_WAH: state_q <= ST_WAL;
              ST_WAL: state_q <= ST_WR;
              default: state_q <= state_q;
            endcase
          end
        end
      endcase
    end
  end

  // Acknowledge pending for each accepted byte
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_pend_q <= 1'b0;
    end else if (start_det || stop_det || state_q == ST_PROG) begin
      ack_pend_q <= 1'b0;
    end else if (byte_done) begin
      ack_pend_q <= (state_q == ST_DEV) ? match :
                    (state_q == ST_WAH || state_q == ST_WAL ||
                     state_q == ST_WR);
    end else if (scl_fall && bit_cnt_q == CNT_BYTE) begin
      ack_pend_q <= 1'b0;
    end
  end

  // Read continues while the controller acknowledges
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cont_q <= 1'b0;
    end else if (start_det || stop_det) begin
      cont_q <= 1'b0;
    end else if (byte_done && state_q == ST_DEV) begin
      cont_q <= match & rx_byte[0];
    end else if (scl_rise && bit_cnt_q == CNT_BYTE && state_q == ST_RD) begin
      cont_q <= ~sda_s;
    end
  end

  // Marks that a write carried data
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wrote_q <= 1'b0;
    end else if (start_det || state_q == ST_PROG) begin
      wrote_q <= 1'b0;
    end else if (mem_we) begin
      wrote_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hi_q <= '0;
      addr_q <= ADDR_RESET;
    end else if (byte_done && state_q == ST_WAH) begin
      // Top three bits of the high byte dropped
      hi_q <= rx_byte[HI_ADDR_W-1:0];
    end else if (byte_done && state_q == ST_WAL) begin
      // Address load, also for a dummy write
      addr_q <= {hi_q, rx_byte};
    end else if (mem_we) begin
      // Page wrap on the low five bits
      addr_q <= {addr_q[ADDR_W-1:PAGE_W],
                 addr_q[PAGE_W-1:0] + 5'h01};
    end else if (rd_load) begin
      addr_q <= addr_q + 13'h0001;
    end
  end

  // Output changes after falling clock edges; start, stop and programming release it at once
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sda_oe_q <= 1'b0;
      tx_q <= '0;
    end else if (state_q == ST_PROG || start_det || stop_det) begin
      sda_oe_q <= 1'b0;
    end else if (scl_fall) begin
      case (bit_cnt_q)
        // Drive acknowledge during the ninth pulse
        CNT_BYTE: sda_oe_q <= ack_pend_q;
        CNT_ACK: begin
          if (rd_load) begin
            tx_q <= {rdata[BYTE_W-2:0], 1'b0};
            sda_oe_q <= ~rdata[BYTE_W-1];
          end else begin
            sda_oe_q <= 1'b0;
          end
        end
        CNT_RESET: sda_oe_q <= 1'b0;
        default: begin
          if (state_q == ST_RD && cont_q) begin
            sda_oe_q <= ~tx_q[BYTE_W-1];
            tx_q <= {tx_q[BYTE_W-2:0], 1'b0};
          end else begin
            sda_oe_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // Data output level is always low
  always_ff @(posedge clk) begin
    sda_o_q <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prog_cnt_q <= '0;
    end else if (state_q == ST_PROG) begin
      prog_cnt_q <= prog_cnt_q + PW'(1);
    end else begin
      prog_cnt_q <= '0;
    end
  end

  // Standby when idle, including after a read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      standby_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      standby_q <= (state_q == ST_IDLE);
      busy_q <= (state_q == ST_PROG);
    end
  end

  ees_mem #(
    .DEPTH(PAGE_COUNT * PAGE_BYTES),
    .AW(ADDR_W)
  ) u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(addr_q),
    .wdata(rx_byte),
    .raddr(addr_q),
    .rdata_q(rdata)
  );

  assign sda_o = sda_o_q;
  assign sda_oe = sda_oe_q;
  assign standby = standby_q;
  assign prog_busy = busy_q;

  chk_never_high: assert property (
    @(posedge clk) disable iff (!rst_b)
    !sda_o_q)
    else $error("data line driven high");

  chk_ack_ninth: assert property (
    @(posedge clk) disable iff (!rst_b)
    (scl_fall && bit_cnt_q == CNT_BYTE && ack_pend_q && !start_det &&
     !stop_det) |=> sda_oe_q)
    else $error("acknowledge not driven");

  chk_prog_silent: assert property (
    @(posedge clk) disable iff (!rst_b)
    (state_q == ST_PROG) |=> !sda_oe_q && !ack_pend_q)
    else $error("bus answered while programming");

  chk_stop_prog: assert property (
    @(posedge clk) disable iff (!rst_b)
    (stop_det && state_q == ST_WR && wrote_q) |=>
      (state_q == ST_PROG)[*8] ##1 busy_q)
    else $error("program cycle not started");

  chk_start_seen: assert property (
    @(posedge clk) disable iff (!rst_b)
    (start_det && state_q != ST_PROG) |=>
      state_q == ST_DEV && bit_cnt_q == CNT_RESET && !sda_oe_q)
    else $error("start not taken");

  chk_nomatch_quiet: assert property (
    @(posedge clk) disable iff (!rst_b)
    (byte_done && state_q == ST_DEV && !match && !start_det &&
     !stop_det) |=> !ack_pend_q && state_q == ST_IDLE && !sda_oe_q)
    else $error("mismatched word acknowledged");

  chk_page_wrap: assert property (
    @(posedge clk) disable iff (!rst_b)
    (mem_we && !start_det && !stop_det) |=>
      addr_q[ADDR_W-1:PAGE_W] == $past(addr_q[ADDR_W-1:PAGE_W]) &&
      addr_q[PAGE_W-1:0] == $past(addr_q[PAGE_W-1:0]) + 5'h01)
    else $error("page address not wrapped");

  chk_hi_masked: assert property (
    @(posedge clk) disable iff (!rst_b)
    (byte_done && state_q == ST_WAL && !start_det && !stop_det) |=>
      addr_q == {$past(hi_q), $past(rx_byte)})
    else $error("word address load wrong");

  chk_read_incr: assert property (
    @(posedge clk) disable iff (!rst_b)
    (rd_load && !start_det && !stop_det) |=>
      addr_q == $past(addr_q) + 13'h0001 && sda_oe_q == !$past(rdata[7]))
    else $error("read address not advanced");

  chk_read_standby: assert property (
    @(posedge clk) disable iff (!rst_b)
    (stop_det && state_q == ST_RD) |-> ##2 standby_q)
    else $error("no standby after read stop");
endmodule

/* File: ees_ctrl_model.sv */
// Bus controller model that drives the serial EEPROM target
`timescale 1ns/1ps

module ees_ctrl_model (
  input wire logic sda_in,
  output logic scl_o,
  output logic sda_pull,
  output logic [8:0] res_q,
  output logic res_tgl
);
  localparam time Q = 40ns;
  initial begin
    scl_o = 1'b1;
    sda_pull = 1'b0;
    res_q = 9'h000;
    res_tgl = 1'b0;
  end
  task automatic bit_io(input logic b, output logic s);
    #Q sda_pull = ~b;
    #Q scl_o = 1'b1;
    #Q s = sda_in;
    #Q scl_o = 1'b0;
  endtask
  task automatic report(input logic [8:0] v);
    res_q = v;
    res_tgl = ~res_tgl;
  endtask
  task automatic recover();
    logic s;
    #Q scl_o = 1'b0;
    repeat (9) bit_io(1'b1, s);
  endtask
  task automatic start();
    #Q sda_pull = 1'b0;
    #Q scl_o = 1'b1;
    #(2*Q) sda_pull = 1'b1;
    #(2*Q) scl_o = 1'b0;
  endtask
  task automatic stop();
    #Q sda_pull = 1'b1;
    #Q scl_o = 1'b1;
    #(2*Q) sda_pull = 1'b0;
    #(2*Q);
  endtask
  // byte out, answer on ninth pulse
  task automatic send_byte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    report({1'b1, 7'h00, s});
  endtask
  // byte in, low acknowledge asks for more
  task automatic read_byte(input logic more);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~more, s);
    report({1'b0, d});
  endtask
endmodule

/* File: tb_i2c_serial_eeprom_target.sv */
// Self-checking bench for the serial EEPROM target
`timescale 1ns/1ps

module tb_i2c_serial_eeprom_target;
  import ees_pkg::*;
  localparam int PROG = 400;
  logic clk, rst_b, scl, sda, sda_o, sda_oe, standby, prog_busy;
  logic sel_hi, sel_mid, sel_lo, pull, res_tgl;
  logic [8:0] res;
  logic [8:0] exp_q[$];
  logic [7:0] page_m[32];
  logic [7:0] w[2];
  logic [2:0] sel;
  logic [12:0] base;
  int bad_count, checked, seed, busy_n;

  initial clk = 1'b0;
  always #5 clk = ~clk;
  assign sda = (pull === 1'b1 || sda_oe === 1'b1) ? 1'b0 : 1'b1;

  ees_target #(.TYPE_CODE(TYPE_CODE_DEF), .PROG_CYCLES(PROG)) dut (
    .clk(clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .target_select_bit_hi(sel_hi),
    .target_select_bit_mid(sel_mid), .target_select_bit_lo(sel_lo),
    .standby(standby), .prog_busy(prog_busy)
  );
  ees_ctrl_model ctrl (
    .sda_in(sda), .scl_o(scl), .sda_pull(pull), .res_q(res),
    .res_tgl(res_tgl)
  );

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  always @(res_tgl) begin
    #1;
    if (rst_b === 1'b1) begin
      if (exp_q.size() > 0) chk(res, exp_q.pop_front());
      else chk(res, 9'h1ff);
    end
  end
  always @(posedge clk) if (sda_oe === 1'b1) chk({8'h00, sda_o}, 9'h000);
  always @(posedge clk) if (prog_busy === 1'b1) busy_n <= busy_n + 1;

  task automatic wr_byte(input logic [7:0] d, input logic a);
    exp_q.push_back({1'b1, 7'h00, a});
    ctrl.send_byte(d);
  endtask
  task automatic rd_byte(input logic [7:0] d, input logic more);
    exp_q.push_back({1'b0, d});
    ctrl.read_byte(more);
  endtask
  task automatic dev(input logic [7:0] word, input logic a);
    ctrl.start();
    wr_byte(word, a);
  endtask
  task automatic set_addr(input logic [12:0] ad, input logic [2:0] junk);
    dev({TYPE_CODE_DEF, sel, 1'b0}, 1'b0);
    wr_byte({junk, ad[12:8]}, 1'b0);
    wr_byte(ad[7:0], 1'b0);
  endtask
  task automatic fin_wr(input logic probe);
    int n;
    busy_n = 0;
    ctrl.stop();
    repeat (5) @(negedge clk);
    chk({8'h00, prog_busy}, 9'h001);
    if (probe) begin
      dev({TYPE_CODE_DEF, sel, 1'b0}, 1'b1);
      ctrl.stop();
    end
    n = 0;
    while (prog_busy !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    repeat (4) @(negedge clk);
    chk({8'h00, busy_n >= PROG && busy_n <= PROG + 2}, 9'h001);
    chk({8'h00, standby}, 9'h001);
  endtask
  task automatic stop_test();
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    seed = 32'h2f9b424c;
    rst_b = 1'b0;
    {sel_hi, sel_mid, sel_lo} = 3'h0;
    sel = 3'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(negedge clk);
    chk({8'h00, standby}, 9'h001);
    chk({8'h00, prog_busy}, 9'h000);
    base = 13'($random(seed)) & 13'h1fe0;
    ctrl.recover();
    // Page write of 34 bytes from offset 30, junk in top address bits
    set_addr(base | 13'h001e, 3'h7);
    for (int i = 0; i < 34; i++) begin
      w[0] = 8'($random(seed));
      page_m[(30 + i) % 32] = w[0];
      wr_byte(w[0], 1'b0);
    end
    fin_wr(1'b1);
    // Random read of the whole page
    set_addr(base, 3'h0);
    dev({TYPE_CODE_DEF, sel, 1'b1}, 1'b0);
    for (int i = 0; i < 32; i++) rd_byte(page_m[i], i < 31);
    ctrl.stop();
    repeat (4) @(negedge clk);
    chk({8'h00, standby}, 9'h001);
    // Byte writes at both ends of memory
    for (int i = 0; i < 2; i++) begin
      w[i] = 8'($random(seed));
      set_addr(i == 0 ? 13'h0000 : 13'h1fff, 3'h0);
      wr_byte(w[i], 1'b0);
      fin_wr(1'b0);
    end
    set_addr(13'h1fff, 3'h0);
    ctrl.stop();
    dev({TYPE_CODE_DEF, sel, 1'b1}, 1'b0);
    rd_byte(w[1], 1'b0);
    ctrl.stop();
    dev({TYPE_CODE_DEF, sel, 1'b1}, 1'b0);
    rd_byte(w[0], 1'b0);
    ctrl.stop();
    set_addr(13'h1fff, 3'h0);
    dev({TYPE_CODE_DEF, sel, 1'b1}, 1'b0);
    rd_byte(w[1], 1'b1);
    rd_byte(w[0], 1'b0);
    ctrl.stop();
    // Selection pins moved away from the default
    sel = 3'($random(seed)) | 3'h1;
    @(posedge clk);
    {sel_hi, sel_mid, sel_lo} <= sel;
    repeat (4) @(negedge clk);
    dev({TYPE_CODE_DEF, 3'h0, 1'b0}, 1'b1);
    ctrl.stop();
    dev({~TYPE_CODE_DEF, sel, 1'b0}, 1'b1);
    ctrl.stop();
    dev({TYPE_CODE_DEF, sel, 1'b0}, 1'b0);
    ctrl.stop();
    repeat (10) @(negedge clk);
    chk({8'h00, exp_q.size() == 0}, 9'h001);
    stop_test();
  end
  initial begin
    #400us;
    bad_count++;
    stop_test();
  end
endmodule
